// >>> design/sspm_pkg.sv
package sspm_pkg;

  localparam int NGPIO = 12;
  localparam int CNT_W = 11;

  // Clock and bus rates
  localparam int CLK_MHZ  = 250;
  localparam int SLOW_KHZ = 100;
  localparam int FAST_KHZ = 400;
  // Half periods round up so the bus never runs above its rate
  localparam logic [CNT_W-1:0] HALF_SLOW =
    CNT_W'((CLK_MHZ * 1000 + 2 * SLOW_KHZ - 1) / (2 * SLOW_KHZ));
  localparam logic [CNT_W-1:0] HALF_FAST =
    CNT_W'((CLK_MHZ * 1000 + 2 * FAST_KHZ - 1) / (2 * FAST_KHZ));

  // Register byte offsets
  localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFS_DIR      = 8'h04;
  localparam logic [7:0] OFS_OUT      = 8'h08;
  localparam logic [7:0] OFS_IN       = 8'h0c;
  localparam logic [7:0] OFS_STRAP    = 8'h10;

  // Reset values
  localparam logic [NGPIO-1:0] FUNC_SEL_RST = 12'h000;
  localparam logic [NGPIO-1:0] DIR_RST      = 12'h000;
  localparam logic [NGPIO-1:0] OUT_RST      = 12'h000;

  // Alternate function kinds per pin
  localparam logic [NGPIO-1:0] ALT_OUT_MASK   = 12'hf83;
  localparam logic [NGPIO-1:0] ALT_IN_MASK    = 12'h03c;
  localparam logic [NGPIO-1:0] ALT_VALID_MASK = 12'hfbf;

  // Pin positions of alternate functions
  localparam int PIN_RST2  = 0;
  localparam int PIN_RST4  = 1;
  localparam int PIN_IRQ0  = 2;
  localparam int PIN_EVENT = 7;
  localparam int PIN_RST1  = 8;
  localparam int PIN_RST3  = 9;
  localparam int PIN_RST5  = 10;
  localparam int PIN_RST6  = 11;

  // Strap status field positions
  localparam int ST_EE_LSB   = 0;
  localparam int ST_SLV_LSB  = 4;
  localparam int ST_SLOW     = 8;
  localparam int ST_MERGED   = 9;
  localparam int ST_DS_CC    = 10;
  localparam int ST_US_CC    = 11;
  localparam int ST_CAPTURED = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0] LANES_MERGED = 8'hff;
  localparam logic [7:0] LANES_SPLIT  = 8'h0f;

endpackage : sspm_pkg

// >>> design/sspm_top.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Operation
// - EEPROM bus address bits 4:1 come from the four master address straps.
// - Master bus clock toggles only during EEPROM or expander accesses, else idle.
// - Slave bus answers only the address built from straps on bits 5,3:1.
// - Slow strap selects 100 kHz master bus, otherwise 400 kHz.
// - Nothing, including software, can override the strap-chosen master bus speed.
// - Merge strap low joins ports 0 and 1 into one eight-lane port.
// - When merged, port 1 lanes serve as lanes four to seven of port 0.
// - Merge strap high keeps ports 0 and 1 as separate four-lane ports.
// - An undriven merge strap reads low, so merging is the default.
// - Each general pin except pin 6 selects plain input/output or its alternate function.
// - Alternate pins 0 and 1 drive resets of downstream ports 2 and 4.
// - Alternate pins 8 to 11 drive resets of downstream ports 1,3,5,6.
// - Alternate pins 2 to 5 receive expander interrupts 0 to 3.
// - Alternate pin 7 drives the general-purpose event output.
// - Downstream common-clock strap marks downstream ports as sharing reference clock.
// - Upstream common-clock strap marks upstream port as sharing reference clock.
// - Names ending in N are active low; all others active high.
module sspm_top
  import sspm_pkg::*;
#(
  parameter logic [6:0] EE_ADDR_FIXED  = 7'h00,
  parameter logic [6:0] SLV_ADDR_FIXED = 7'h00
) (
  input  wire  logic             MCLK,                          // System clock
  input  wire  logic             SYS_RST,                       // Fundamental reset
  // Straps
  input  wire  logic [3:0]       EEPROM_BUS_ADDR_STRAP,         // Address bits 4:1
  input  wire  logic [3:0]       SLAVE_BUS_ADDR_STRAP,          // Address bits 5,3,2,1
  input  wire  logic             MASTER_BUS_SLOW_STRAP,         // 100 kHz when high
  input  wire  logic             PORT_PAIR_MERGE_STRAP_N,       // Merge when low
  input  wire  logic             PORT_PAIR_MERGE_STRAP_N_DRV,   // Board drives the strap
  input  wire  logic             DOWNSTREAM_COMMON_CLOCK_STRAP, // Downstream common clock
  input  wire  logic             UPSTREAM_COMMON_CLOCK_STRAP,   // Upstream common clock
  // Master management bus clock, open drain
  input  wire  logic             MASTER_BUS_ACCESS,             // Engine is accessing
  output logic                   MASTER_MGMT_BUS_CLOCK_O,       // Clock pin level
  output logic                   MASTER_MGMT_BUS_CLOCK_OE,      // Clock pin pulled low
  output logic [6:0]             EEPROM_BUS_ADDR,               // EEPROM device address
  // Slave management bus address check
  input  wire  logic [6:0]       SLAVE_RX_ADDR,                 // Received address
  output logic                   SLAVE_ADDR_HIT,                // Address is ours
  output logic [6:0]             SLAVE_BUS_ADDR,                // Our address
  // Port configuration
  output logic                   PORT_PAIR_MERGED,              // Ports 0 and 1 joined
  output logic [7:0]             PORT0_LANE_MASK,               // Physical lanes of port 0
  output logic                   PORT1_ENABLE,                  // Port 1 independent
  output logic                   DOWNSTREAM_COMMON_CLOCK,       // Downstream shares clock
  output logic                   UPSTREAM_COMMON_CLOCK,         // Upstream shares clock
  // Alternate function sources and sinks
  input  wire  logic [6:1]       DOWNSTREAM_PORT_RESET,         // Per port, high = reset
  input  wire  logic             SYSTEM_EVENT,                  // Event request
  output logic [3:0]             EXPANDER_IRQ,                  // Expander interrupts
  // General pins
  input  wire  logic [NGPIO-1:0] GPIO_I,                        // Pin levels
  output logic [NGPIO-1:0]       GPIO_O,                        // Pin drive levels
  output logic [NGPIO-1:0]       GPIO_OE,                       // Pin drive enables
  // AXI4-Lite slave
  input  wire  logic [7:0]       S_AXI_AWADDR,                  // Write address
  input  wire  logic             S_AXI_AWVALID,                 // Write address valid
  output logic                   S_AXI_AWREADY,                 // Write address ready
  input  wire  logic [31:0]      S_AXI_WDATA,                   // Write data
  input  wire  logic [3:0]       S_AXI_WSTRB,                   // Write strobes
  input  wire  logic             S_AXI_WVALID,                  // Write data valid
  output logic                   S_AXI_WREADY,                  // Write data ready
  output logic [1:0]             S_AXI_BRESP,                   // Write response
  output logic                   S_AXI_BVALID,                  // Write response valid
  input  wire  logic             S_AXI_BREADY,                  // Write response ready
  input  wire  logic [7:0]       S_AXI_ARADDR,                  // Read address
  input  wire  logic             S_AXI_ARVALID,                 // Read address valid
  output logic                   S_AXI_ARREADY,                 // Read address ready
  output logic [31:0]            S_AXI_RDATA,                   // Read data
  output logic [1:0]             S_AXI_RRESP,                   // Read response
  output logic                   S_AXI_RVALID,                  // Read data valid
  input  wire  logic             S_AXI_RREADY                   // Read data ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture

  logic             captured_r;
  logic [3:0]       ee_strap_r;
  logic [3:0]       slv_strap_r;
  logic             slow_r;
  logic             merged_r;
  logic             ds_cc_r;
  logic             us_cc_r;
  wire  logic       merge_n_seen;

  // Undriven strap reads as the pull-down level
  assign merge_n_seen = PORT_PAIR_MERGE_STRAP_N_DRV & PORT_PAIR_MERGE_STRAP_N;

  // Caught on the first edge after release, then frozen; straps must be static by then
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      captured_r  <= 1'b0;
      ee_strap_r  <= 4'h0;
      slv_strap_r <= 4'h0;
      slow_r      <= 1'b0;
      merged_r    <= 1'b0;
      ds_cc_r     <= 1'b0;
      us_cc_r     <= 1'b0;
    end else if (!captured_r) begin
      captured_r  <= 1'b1;
      ee_strap_r  <= EEPROM_BUS_ADDR_STRAP;
      slv_strap_r <= SLAVE_BUS_ADDR_STRAP;
      slow_r      <= MASTER_BUS_SLOW_STRAP;
      merged_r    <= ~merge_n_seen;
      ds_cc_r     <= DOWNSTREAM_COMMON_CLOCK_STRAP;
      us_cc_r     <= UPSTREAM_COMMON_CLOCK_STRAP;
    end
  end

  assign EEPROM_BUS_ADDR = {EE_ADDR_FIXED[6:5], ee_strap_r, EE_ADDR_FIXED[0]};
  assign SLAVE_BUS_ADDR  = {SLV_ADDR_FIXED[6], slv_strap_r[3], SLV_ADDR_FIXED[4],
                            slv_strap_r[2:0], SLV_ADDR_FIXED[0]};
  assign SLAVE_ADDR_HIT  = captured_r && (SLAVE_RX_ADDR == SLAVE_BUS_ADDR);

  assign PORT_PAIR_MERGED        = merged_r;
  assign PORT0_LANE_MASK         = merged_r ? LANES_MERGED : LANES_SPLIT;
  assign PORT1_ENABLE            = captured_r & ~merged_r;
  assign DOWNSTREAM_COMMON_CLOCK = ds_cc_r;
  assign UPSTREAM_COMMON_CLOCK   = us_cc_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Master bus clock generator

  logic [CNT_W-1:0] half_cnt_r;
  logic [CNT_W-1:0] half_cnt_nxt;
  logic             scl_low_r;
  logic             scl_low_nxt;
  wire  logic [CNT_W-1:0] half_len;
  wire  logic             half_done;

  // Only the captured strap picks the rate; no register reaches it
  assign half_len  = slow_r ? HALF_SLOW : HALF_FAST;
  assign half_done = (half_cnt_r == half_len - CNT_W'(1));

  // An access ending mid-phase releases the line at once, leaving it high
  assign half_cnt_nxt = (!MASTER_BUS_ACCESS || half_done) ? '0 : half_cnt_r + CNT_W'(1);
  assign scl_low_nxt  = MASTER_BUS_ACCESS && (half_done ? ~scl_low_r : scl_low_r);

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      half_cnt_r <= '0;
      scl_low_r  <= 1'b0;
    end else begin
      half_cnt_r <= half_cnt_nxt;
      scl_low_r  <= scl_low_nxt;
    end
  end

  assign MASTER_MGMT_BUS_CLOCK_O  = 1'b0;
  assign MASTER_MGMT_BUS_CLOCK_OE = scl_low_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [NGPIO-1:0] func_sel_r;
  logic [NGPIO-1:0] dir_r;
  logic [NGPIO-1:0] out_r;
  logic             aw_hold_r;
  logic [7:0]       aw_addr_r;
  logic             w_hold_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;

  wire  logic       aw_take;
  wire  logic       w_take;
  wire  logic       do_write;
  wire  logic       ar_take;
  wire  logic       wr_func;
  wire  logic       wr_dir;
  wire  logic       wr_out;
  wire  logic       wr_hit;
  wire  logic       rd_hit;
  wire  logic [NGPIO-1:0] wmask;
  wire  logic [NGPIO-1:0] wval;
  wire  logic [31:0]      strap_word;
  wire  logic [31:0]      rd_word;

  assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_hold_r & ~bvalid_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign aw_take  = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_take   = S_AXI_WVALID & S_AXI_WREADY;
  assign do_write = aw_hold_r & w_hold_r;
  assign ar_take  = S_AXI_ARVALID & S_AXI_ARREADY;

  assign wr_func = do_write && (aw_addr_r[7:2] == OFS_FUNC_SEL[7:2]);
  assign wr_dir  = do_write && (aw_addr_r[7:2] == OFS_DIR[7:2]);
  assign wr_out  = do_write && (aw_addr_r[7:2] == OFS_OUT[7:2]);
  assign wr_hit  = wr_func | wr_dir | wr_out;
  assign wmask   = {{4{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wval    = w_data_r[NGPIO-1:0];

  assign strap_word = {19'h0, captured_r, us_cc_r, ds_cc_r, merged_r, slow_r,
                       slv_strap_r, ee_strap_r};
  assign rd_hit  = (S_AXI_ARADDR[7:2] <= OFS_STRAP[7:2]);
  assign rd_word =
    (S_AXI_ARADDR[7:2] == OFS_FUNC_SEL[7:2]) ? {20'h0, func_sel_r} :
    (S_AXI_ARADDR[7:2] == OFS_DIR[7:2])      ? {20'h0, dir_r} :
    (S_AXI_ARADDR[7:2] == OFS_OUT[7:2])      ? {20'h0, out_r} :
    (S_AXI_ARADDR[7:2] == OFS_IN[7:2])       ? {20'h0, GPIO_I} :
    (S_AXI_ARADDR[7:2] == OFS_STRAP[7:2])    ? strap_word : 32'h0;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Pin 6 select bit is held at zero so the reserved function can never engage
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      func_sel_r <= FUNC_SEL_RST;
      dir_r      <= DIR_RST;
      out_r      <= OUT_RST;
    end else begin
      if (wr_func) begin
        func_sel_r <= ((func_sel_r & ~wmask) | (wval & wmask)) & ALT_VALID_MASK;
      end
      if (wr_dir) begin
        dir_r <= (dir_r & ~wmask) | (wval & wmask);
      end
      if (wr_out) begin
        out_r <= (out_r & ~wmask) | (wval & wmask);
      end
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP  = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA  = rdata_r;
  assign S_AXI_RRESP  = rresp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin multiplexer

  wire  logic [NGPIO-1:0] alt_val;
  logic [NGPIO-1:0]       pin_o_r;
  logic [NGPIO-1:0]       pin_oe_r;

  // Internal requests are active high, the pins carry them active low
  assign alt_val = {~DOWNSTREAM_PORT_RESET[6], ~DOWNSTREAM_PORT_RESET[5],
                    ~DOWNSTREAM_PORT_RESET[3], ~DOWNSTREAM_PORT_RESET[1],
                    ~SYSTEM_EVENT, 1'b1, 4'hf,
                    ~DOWNSTREAM_PORT_RESET[4], ~DOWNSTREAM_PORT_RESET[2]};

  genvar gi;
  generate
    for (gi = 0; gi < NGPIO; gi = gi + 1) begin : g_pin
      wire logic alt_on;
      assign alt_on = func_sel_r[gi];
      always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          pin_o_r[gi]  <= 1'b0;
          pin_oe_r[gi] <= 1'b0;
        end else if (alt_on) begin
          pin_o_r[gi]  <= alt_val[gi];
          pin_oe_r[gi] <= ALT_OUT_MASK[gi];
        end else begin
          pin_o_r[gi]  <= out_r[gi];
          pin_oe_r[gi] <= dir_r[gi];
        end
      end
    end
  endgenerate

  // Deasserted while the pin is not in its alternate role
  assign EXPANDER_IRQ = func_sel_r[PIN_IRQ0 +: 4] & ~GPIO_I[PIN_IRQ0 +: 4];

  assign GPIO_O  = pin_o_r;
  assign GPIO_OE = pin_oe_r;

endmodule : sspm_top

// >>> verif/sspm_properties.sv
`timescale 1ns/1ps
module sspm_properties
  import sspm_pkg::*;
(
  input wire logic             MCLK,                     // Clock
  input wire logic             SYS_RST,                  // Reset
  input wire logic             MASTER_BUS_ACCESS,        // Engine busy
  input wire logic             MASTER_BUS_SLOW_STRAP,    // Rate strap
  input wire logic             MASTER_MGMT_BUS_CLOCK_OE, // Clock pulled low
  input wire logic [6:0]       EEPROM_BUS_ADDR,          // EEPROM address
  input wire logic [6:0]       SLAVE_RX_ADDR,            // Received address
  input wire logic             SLAVE_ADDR_HIT,           // Address match
  input wire logic [6:0]       SLAVE_BUS_ADDR,           // Own address
  input wire logic             PORT_PAIR_MERGED,         // Ports joined
  input wire logic [7:0]       PORT0_LANE_MASK,          // Port 0 lanes
  input wire logic             PORT1_ENABLE,             // Port 1 alone
  input wire logic             DOWNSTREAM_COMMON_CLOCK,  // Downstream clock
  input wire logic             UPSTREAM_COMMON_CLOCK,    // Upstream clock
  input wire logic [3:0]       EXPANDER_IRQ,             // Interrupts
  input wire logic [NGPIO-1:0] GPIO_I,                   // Pin levels
  input wire logic [NGPIO-1:0] GPIO_OE                   // Pin enables
);
  logic [11:0] run_r;
  logic [11:0] run_nxt;
  logic        oe_d_r;

  // Phase length is counted here, far beyond what a repetition could unroll
  assign run_nxt = (!MASTER_BUS_ACCESS || (MASTER_MGMT_BUS_CLOCK_OE != oe_d_r)) ? 12'h000
                 : run_r + 12'h001;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      run_r  <= 12'h000;
      oe_d_r <= 1'b0;
    end else begin
      run_r  <= run_nxt;
      oe_d_r <= MASTER_MGMT_BUS_CLOCK_OE;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb_main @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // Capture lands on the first edge, so three clean edges are needed
  sequence s_settled;
    !SYS_RST [*3];
  endsequence

  chk_clock_idle: assert property (!MASTER_BUS_ACCESS |=> !MASTER_MGMT_BUS_CLOCK_OE)
    else $error("bus clock pulled while idle");
  chk_clock_rate: assert property (MASTER_BUS_ACCESS && $changed(MASTER_MGMT_BUS_CLOCK_OE)
    |-> (MASTER_BUS_SLOW_STRAP ? (run_r inside {[HALF_SLOW - 3 : HALF_SLOW + 3]})
                               : (run_r inside {[HALF_FAST - 3 : HALF_FAST + 3]})))
    else $error("bus clock half period wrong");
  chk_straps_held: assert property (s_settled |-> $stable({EEPROM_BUS_ADDR,
    SLAVE_BUS_ADDR, PORT_PAIR_MERGED, DOWNSTREAM_COMMON_CLOCK, UPSTREAM_COMMON_CLOCK}))
    else $error("strap values moved after capture");
  chk_address_hit: assert property (s_settled
    |-> SLAVE_ADDR_HIT == (SLAVE_RX_ADDR == SLAVE_BUS_ADDR))
    else $error("slave address match wrong");
  chk_split_lanes: assert property (PORT1_ENABLE
    |-> !PORT_PAIR_MERGED && PORT0_LANE_MASK == 8'h0f)
    else $error("split port lanes wrong");
  chk_merged_lanes: assert property (PORT_PAIR_MERGED
    |-> PORT0_LANE_MASK == 8'hff && !PORT1_ENABLE)
    else $error("merged port lanes wrong");
  chk_irq_from_pin: assert property ((EXPANDER_IRQ & GPIO_I[5:2]) == 4'h0)
    else $error("expander interrupt on high pin");
  chk_pins_released: assert property ($fell(SYS_RST) |-> (GPIO_OE == 12'h000) [*2])
    else $error("pin driven after reset");
endmodule : sspm_properties

bind sspm_top sspm_properties sspm_properties_inst (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .MASTER_BUS_ACCESS(MASTER_BUS_ACCESS),
  .MASTER_BUS_SLOW_STRAP(MASTER_BUS_SLOW_STRAP),
  .MASTER_MGMT_BUS_CLOCK_OE(MASTER_MGMT_BUS_CLOCK_OE), .EEPROM_BUS_ADDR(EEPROM_BUS_ADDR),
  .SLAVE_RX_ADDR(SLAVE_RX_ADDR), .SLAVE_ADDR_HIT(SLAVE_ADDR_HIT),
  .SLAVE_BUS_ADDR(SLAVE_BUS_ADDR), .PORT_PAIR_MERGED(PORT_PAIR_MERGED),
  .PORT0_LANE_MASK(PORT0_LANE_MASK), .PORT1_ENABLE(PORT1_ENABLE),
  .DOWNSTREAM_COMMON_CLOCK(DOWNSTREAM_COMMON_CLOCK),
  .UPSTREAM_COMMON_CLOCK(UPSTREAM_COMMON_CLOCK), .EXPANDER_IRQ(EXPANDER_IRQ),
  .GPIO_I(GPIO_I), .GPIO_OE(GPIO_OE)
);

// >>> verif/sspm_board.sv
`timescale 1ns/1ps
module sspm_board (
  input  wire logic        clk,     // System clock
  input  wire logic        rst,     // Fundamental reset
  input  wire logic [12:0] cfg,     // Wanted strap levels
  output logic      [12:0] straps,  // Strap pins
  input  wire logic [11:0] pin_o,   // Device levels
  input  wire logic [11:0] pin_oe,  // Device enables
  input  wire logic [11:0] ext_en,  // Board drives pin
  input  wire logic [11:0] ext_lvl, // Board level
  output logic      [11:0] pin_i    // Resolved levels
);
  logic [12:0] cfg_r;

  // Straps only move while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= cfg;
    end
  end
  // Undriven merge strap sits on its pull-down
  assign straps = {cfg_r[12], cfg_r[11] & cfg_r[12], cfg_r[10:0]};
  // Expander lines are open drain, so a free pin floats high
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl) | (~pin_oe & ~ext_en);
endmodule : sspm_board

// >>> verif/sspm_top_tb.sv
`timescale 1ns/1ps
module sspm_top_tb;
  import sspm_pkg::*;

  logic             mclk, sys_rst, access, sys_event;
  logic [12:0]      cfg;
  logic [12:0]      straps;
  logic [NGPIO-1:0] ext_en, ext_lvl, gpio_i, gpio_o, gpio_oe;
  logic [6:0]       rx_addr, ee_addr, slv_addr;
  logic [6:1]       port_rst;
  logic [7:0]       lane_mask, awaddr, araddr;
  logic [3:0]       irq, wstrb;
  logic [31:0]      wdata, rdata;
  logic [1:0]       bresp, rresp;
  logic             clk_o, clk_oe, hit, merged, p1_en, ds_cc, us_cc;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready;
  int               errors, compares;

  sspm_top sspm_top_inst (
    .MCLK(mclk), .SYS_RST(sys_rst),
    .EEPROM_BUS_ADDR_STRAP(straps[3:0]), .SLAVE_BUS_ADDR_STRAP(straps[7:4]),
    .MASTER_BUS_SLOW_STRAP(straps[8]), .DOWNSTREAM_COMMON_CLOCK_STRAP(straps[9]),
    .UPSTREAM_COMMON_CLOCK_STRAP(straps[10]), .PORT_PAIR_MERGE_STRAP_N(straps[11]),
    .PORT_PAIR_MERGE_STRAP_N_DRV(straps[12]), .MASTER_BUS_ACCESS(access),
    .MASTER_MGMT_BUS_CLOCK_O(clk_o), .MASTER_MGMT_BUS_CLOCK_OE(clk_oe),
    .EEPROM_BUS_ADDR(ee_addr), .SLAVE_RX_ADDR(rx_addr), .SLAVE_ADDR_HIT(hit),
    .SLAVE_BUS_ADDR(slv_addr), .PORT_PAIR_MERGED(merged), .PORT0_LANE_MASK(lane_mask),
    .PORT1_ENABLE(p1_en), .DOWNSTREAM_COMMON_CLOCK(ds_cc), .UPSTREAM_COMMON_CLOCK(us_cc),
    .DOWNSTREAM_PORT_RESET(port_rst), .SYSTEM_EVENT(sys_event), .EXPANDER_IRQ(irq),
    .GPIO_I(gpio_i), .GPIO_O(gpio_o), .GPIO_OE(gpio_oe),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );
  sspm_board sspm_board_inst (
    .clk(mclk), .rst(sys_rst), .cfg(cfg), .straps(straps), .pin_o(gpio_o),
    .pin_oe(gpio_oe), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_i(gpio_i)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic timed_out();
    errors++;
    $display("wrong value wait: expected answer, seen timeout");
    end_of_test();
  endtask : timed_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (int n = 0; n <= 50; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
      if (n == 50) timed_out();
    end
    chk("write resp", er, bresp);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    for (int n = 0; n <= 50; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
      if (n == 50) timed_out();
    end
    chk("read data", ed, rdata);
    chk("read resp", er, rresp);
  endtask : axi_rd
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_straps(input logic [12:0] c, input logic [6:0] ee, input logic [6:0] sa,
                          input logic mg, input logic [31:0] st, input int half);
    int n;
    cfg     <= c;
    sys_rst <= 1'b1;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rx_addr <= sa;
    repeat (3) @(posedge mclk);
    chk("eeprom addr", ee, ee_addr);
    chk("slave addr", sa, slv_addr);
    chk("slave hit", 1, hit);
    chk("merged", mg, merged);
    chk("lane mask", mg ? 8'hff : 8'h0f, lane_mask);
    chk("port1 enable", !mg, p1_en);
    chk("common clocks", c[10:9], {us_cc, ds_cc});
    rx_addr <= sa ^ 7'h08;
    axi_wr(OFS_STRAP, 32'hffffffff, RESP_SLVERR);
    chk("slave miss", 0, hit);
    axi_rd(OFS_STRAP, st, RESP_OKAY);
    chk("clock idle", 0, clk_oe | clk_o);
    access <= 1'b1;
    for (n = 0; n < 1400 && !clk_oe; n++) @(posedge mclk);
    if (n == 1400) timed_out();
    chk("half period", 1, n >= half - 2 && n <= half + 2);
    access <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("clock released", 0, clk_oe);
    $display("strap test done");
  endtask : t_straps

  task automatic t_gpio();
    axi_rd(OFS_FUNC_SEL, 32'h0, RESP_OKAY);
    chk("reset enables", 0, gpio_oe);
    axi_wr(OFS_DIR, 32'hfff, RESP_OKAY);
    axi_wr(OFS_OUT, 32'h0aa, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("plain levels", 32'h0aa, gpio_o & gpio_oe);
    axi_wr(OFS_FUNC_SEL, 32'hfbf, RESP_OKAY);
    axi_rd(OFS_FUNC_SEL, 32'hfbf, RESP_OKAY);
    ext_en  <= 12'h03c;
    ext_lvl <= 12'h014;
    for (int k = 0; k < 2; k++) begin
      port_rst  <= k ? 6'h15 : 6'h2a;
      sys_event <= (k == 0);
      repeat (3) @(posedge mclk);
      chk("alt enables", 32'hfc3, gpio_oe);
      chk("alt levels", k ? 32'h883 : 32'h700, gpio_o & gpio_oe);
    end
    chk("expander irq", 32'ha, irq);
    axi_rd(OFS_IN, 32'h897, RESP_OKAY);
    axi_wr(OFS_FUNC_SEL, 32'h0, RESP_OKAY);
    axi_wr(OFS_DIR, 32'h0, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("plain irq", 0, irq);
    chk("input enables", 0, gpio_oe);
    wstrb <= 4'h1;
    axi_wr(OFS_OUT, 32'hf55, RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(OFS_OUT, 32'h055, RESP_OKAY);
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
    $display("gpio test done");
  endtask : t_gpio
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    {sys_rst, access, sys_event, awvalid, wvalid, arvalid} = 6'h20;
    {cfg, ext_en, ext_lvl, rx_addr, port_rst} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb    = 4'hf;
    bready   = 1'b1;
    rready   = 1'b1;
    errors   = 0;
    compares = 0;
    t_straps(13'h1b5a, 7'h14, 7'h0a, 1'b0, 32'h155a, HALF_SLOW);
    t_gpio();
    t_straps(13'h0cc5, 7'h0a, 7'h28, 1'b1, 32'h1ac5, HALF_FAST);
    end_of_test();
  end
endmodule : sspm_top_tb
